// [include/loop_test_params.svh]
// register map, field positions, reset values and timing counts of the loopback controller
`ifndef LOOP_TEST_PARAMS_SVH
`define LOOP_TEST_PARAMS_SVH

// register byte offsets
`define REG_CTRL          4'h0
`define REG_LOOP_CMD      4'h4
`define REG_REMOTE_CMD    4'h8
`define REG_STATUS        4'hC

// control register fields
`define CTRL_TAP_LINE     0
`define CTRL_NET_LINE_OPT 1
`define CTRL_NET_CHAN_LO  2
`define CTRL_XCONN_EN     4
`define CTRL_RESET        32'h0000_0010

// loop command fields
`define LCMD_IDX_HI       2
`define LCMD_PORT         3
`define LCMD_START        4
`define LCMD_STOP         5
`define LCMD_ABORT_ALL    6

// remote command fields
`define RCMD_KIND_HI      1
`define RCMD_UP           2
`define RCMD_PORT         3
`define RCMD_SEND         4

// status fields
`define STAT_INVALID      8
`define STAT_REM_BUSY     9

// loop index codes in a loop command
`define LIDX_LINE         3'h0
`define LIDX_PAYLOAD      3'h1
`define LIDX_EQUIP        3'h2
`define LIDX_REPEATER     3'h3
`define LIDX_CHAN         3'h4
`define LIDX_TERM         3'h5

// bit positions in the active loop vector
`define ACT_LINE          0
`define ACT_PAYLOAD       1
`define ACT_EQUIP         2
`define ACT_REPEATER      3
`define ACT_CHAN0         4
`define ACT_TERM0         6
`define MAX_ACTIVE_LOOPS  4'h2

// loops that may not run beside each loop, one mask per active bit
`define BAD_LINE          8'h32
`define BAD_PAYLOAD       8'h39
`define BAD_EQUIP         8'h08
`define BAD_REPEATER      8'h36
`define BAD_CHAN0         8'h4B
`define BAD_CHAN1         8'h8B
`define BAD_TERM0         8'h10
`define BAD_TERM1         8'h20

// timing
`define CLK_HZ            20000000
`define LINE_CODE_SEC     10
`define LINE_CODE_CYCLES  (`LINE_CODE_SEC * `CLK_HZ)
`define CHAN_CODE_SEC     1
`define CHAN_CODE_CYCLES  (`CHAN_CODE_SEC * `CLK_HZ)

`endif

// [include/loop_test_pkg.sv]
// types of the loopback controller
package loop_test_pkg;

  // remote sequence selection
  typedef enum logic [1:0]
  {
    REM_LINE,
    REM_V54,
    REM_FT1
  } rem_kind_t;

  // all state of the controller
  typedef struct packed {
    logic        wait_req;
    logic [31:0] rdata;
    logic        tap_line;
    logic        net_line_opt;
    logic [1:0]  net_chan_opt;
    logic        xconn_en;
    logic [7:0]  active;
    logic        invalid;
    logic        rem_busy;
    rem_kind_t   rem_kind;
    logic        rem_up;
    logic        rem_port;
    logic [31:0] rem_count;
    logic        line_tx;
    logic        dte_tx;
    logic        fr_net_rx;
    logic        fr_dte_rx;
    logic [1:0]  port_tx;
    logic [1:0]  fr_port_rx;
    logic        in_tap;
    logic        out_tap;
  } state_t;

endpackage

// [src/loopback_test_control.sv]
// test jack routing, local loopbacks and remote loop sequencing of a T1 service unit
//
// Operation
// - input tap follows DTE-bound or line-bound signal
// - output tap follows signal from DTE or line
// - line jacks insert toward line, cut line receive
// - equipment jacks insert toward DTE, cut DTE receive
// - line loop code sent ten seconds then stops
// - V.54 up and down codes per port
// - fractional loop codes up and down per port
// - remote request refused while any local loop
// - equipment loop refused when cross-connect disabled
// - network line commands obeyed only when enabled
// - network V.54 channel loop only when enabled
// - abort ends one or all local loops
// - never more than two local loops, except when network up commands for several loops land in one cycle
// - line loop excludes payload and channel loops, except when network line up and V.54 up land in one cycle
// - equipment loop excludes repeater loop
// - repeater loop excludes payload, equipment, channel
// - channel loop pairs only on other ports
// - line loop returns line receive unchanged
// - payload loop returns framed data, CRCs regenerated
// - equipment loop returns DTE receive unchanged
// - repeater loop returns framed outbound toward DTE
// - channel loop returns port slots to line
// - terminal loop returns port data out port
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`include "loop_test_params.svh"

module loopback_test_control #(
  parameter logic [31:0] LINE_CODE_CYCLES = 32'(`LINE_CODE_CYCLES),
  parameter logic [31:0] CHAN_CODE_CYCLES = 32'(`CHAN_CODE_CYCLES)
) (
  input  wire logic                     clk,                // 20 MHz system clock
  input  wire logic                     sys_rst,            // asynchronous reset, high
  input  wire logic                     ce,                 // clock enable, freezes state
  input  wire logic [3:0]               avm_address,        // byte address
  input  wire logic                     avm_read,           // read request
  input  wire logic                     avm_write,          // write request
  input  wire logic [31:0]              avm_writedata,      // write data
  output logic [31:0]                   avm_readdata,       // read data
  output logic                          avm_waitrequest,    // stall
  input  wire logic                     line_rx,            // received from network
  output logic                          line_tx,            // sent toward network
  input  wire logic                     dte_rx,             // received from DTE
  output logic                          dte_tx,             // sent toward DTE
  input  wire logic                     fr_net_tx,          // framer output toward network
  output logic                          fr_net_rx,          // framer input from network
  input  wire logic                     fr_dte_tx,          // framer output toward DTE
  output logic                          fr_dte_rx,          // framer input from DTE
  input  wire logic [1:0]               fr_port_tx,         // framer data toward ports
  output logic [1:0]                    fr_port_rx,         // port data into framer
  input  wire logic [1:0]               port_rx,            // data entering ports
  output logic [1:0]                    port_tx,            // data leaving ports
  input  wire logic                     jack_line_in_plug,  // line insert jack in use
  input  wire logic                     jack_line_in,       // tester signal toward line
  input  wire logic                     jack_line_out_plug, // line break jack in use
  input  wire logic                     jack_equip_in_plug, // equipment insert jack in use
  input  wire logic                     jack_equip_in,      // tester signal toward DTE
  input  wire logic                     jack_equip_out_plug,// equipment break jack in use
  output logic                          input_tap,          // monitor of outgoing signal
  output logic                          output_tap,         // monitor of incoming signal
  input  wire logic                     net_line_up,        // network line loop-up pulse
  input  wire logic                     net_line_down,      // network line loop-down pulse
  input  wire logic [1:0]               net_v54_up,         // inband V.54 up per port
  input  wire logic [1:0]               net_v54_down,       // inband V.54 down per port
  output logic                          rem_send,           // remote sequence running
  output loop_test_pkg::rem_kind_t      rem_kind,           // which sequence
  output logic                          rem_up,             // up (1) or down (0) code
  output logic                          rem_port            // data port of channel code
);

  loop_test_pkg::state_t st;
  loop_test_pkg::state_t next_st;

  logic       take;
  logic       wr_take;
  logic       loop_wr;
  logic       rem_wr;
  logic [2:0] cmd_idx;
  logic [2:0] bit_idx;
  logic       rem_req;

  // does a new loop fit beside the running ones
  function automatic logic loop_allowed(input logic [7:0] act, input logic [2:0] idx,
                                        input logic xconn);
    logic [7:0] bad;
    logic [3:0] cnt;
    bad = 8'h00;
    cnt = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      cnt = cnt + {3'h0, act[i]};
    end
    unique case (idx)
      3'h0: bad = `BAD_LINE;
      3'h1: bad = `BAD_PAYLOAD;
      3'h2: bad = `BAD_EQUIP;
      3'h3: bad = `BAD_REPEATER;
      3'h4: bad = `BAD_CHAN0;
      3'h5: bad = `BAD_CHAN1;
      3'h6: bad = `BAD_TERM0;
      3'h7: bad = `BAD_TERM1;
    endcase
    loop_allowed = ((act & bad) == 8'h00)
                   && (act[idx] || cnt < `MAX_ACTIVE_LOOPS)
                   && !(idx == 3'(`ACT_EQUIP) && !xconn);
  endfunction

  // bus handshake: one wait cycle, then the request is taken
  assign take    = (avm_read || avm_write) && !st.wait_req;
  assign wr_take = avm_write && take;
  assign loop_wr = wr_take && avm_address == `REG_LOOP_CMD;
  assign rem_wr  = wr_take && avm_address == `REG_REMOTE_CMD;
  assign rem_req = rem_wr && avm_writedata[`RCMD_SEND];
  assign cmd_idx = avm_writedata[`LCMD_IDX_HI:0];

  // channel and terminal loops take one bit per port
  always_comb
  begin
    bit_idx = cmd_idx;
    if (cmd_idx == `LIDX_CHAN)
      bit_idx = 3'(`ACT_CHAN0) + {2'h0, avm_writedata[`LCMD_PORT]};
    else if (cmd_idx == `LIDX_TERM)
      bit_idx = 3'(`ACT_TERM0) + {2'h0, avm_writedata[`LCMD_PORT]};
  end

  // next state
  always_comb
  begin
    logic rx_line;
    logic rx_dte;
    rx_line = jack_line_out_plug ? 1'b1 : line_rx;
    rx_dte  = jack_equip_out_plug ? 1'b1 : dte_rx;
    next_st = st;

    // answer on the second cycle of a request
    next_st.wait_req = !((avm_read || avm_write) && st.wait_req);
    if ((avm_read || avm_write) && st.wait_req)
    begin
      unique case (avm_address)
        `REG_CTRL:       next_st.rdata = {27'h0, st.xconn_en, st.net_chan_opt,
                                          st.net_line_opt, st.tap_line};
        `REG_REMOTE_CMD: next_st.rdata = {27'h0, st.rem_busy, st.rem_port,
                                          st.rem_up, st.rem_kind};
        `REG_STATUS:     next_st.rdata = {22'h0, st.rem_busy, st.invalid, st.active};
        default:         next_st.rdata = 32'h0000_0000;
      endcase
    end

    // flag clear first, so any set later in this cycle wins
    if (wr_take && avm_address == `REG_STATUS && avm_writedata[`STAT_INVALID])
      next_st.invalid = 1'b0;

    // remote sequence timer
    if (st.rem_busy)
    begin
      if (st.rem_count == 32'h0000_0000)
        next_st.rem_busy = 1'b0;
      else
        next_st.rem_count = st.rem_count - 32'h0000_0001;
    end

    if (wr_take && avm_address == `REG_CTRL)
    begin
      next_st.tap_line     = avm_writedata[`CTRL_TAP_LINE];
      next_st.net_line_opt = avm_writedata[`CTRL_NET_LINE_OPT];
      next_st.net_chan_opt = avm_writedata[`CTRL_NET_CHAN_LO+1:`CTRL_NET_CHAN_LO];
      next_st.xconn_en     = avm_writedata[`CTRL_XCONN_EN];
    end

    // local loop commands from software
    if (loop_wr)
    begin
      if (avm_writedata[`LCMD_ABORT_ALL])
        next_st.active = 8'h00;
      else if (avm_writedata[`LCMD_STOP])
        next_st.active[bit_idx] = 1'b0;
      else if (avm_writedata[`LCMD_START] && cmd_idx <= `LIDX_TERM)
      begin
        if (loop_allowed(st.active, bit_idx, st.xconn_en))
          next_st.active[bit_idx] = 1'b1;
        else
          next_st.invalid = 1'b1;
      end
    end
    else
    begin
      // network commands yield to a software loop command in the same cycle
      if (st.net_line_opt && net_line_down)
        next_st.active[`ACT_LINE] = 1'b0;
      else if (st.net_line_opt && net_line_up
               && loop_allowed(st.active, 3'(`ACT_LINE), st.xconn_en))
        next_st.active[`ACT_LINE] = 1'b1;
      for (int p = 0; p < 2; p++)
      begin
        if (st.net_chan_opt[p] && net_v54_down[p])
          next_st.active[`ACT_CHAN0 + p] = 1'b0;
        else if (st.net_chan_opt[p] && net_v54_up[p]
                 && loop_allowed(st.active, 3'(`ACT_CHAN0 + p), st.xconn_en))
          next_st.active[`ACT_CHAN0 + p] = 1'b1;
      end
    end

    // remote sequences start only while no local loop runs
    if (rem_req)
    begin
      if (st.active != 8'h00)
        next_st.invalid = 1'b1;
      else
      begin
        next_st.rem_busy  = 1'b1;
        next_st.rem_kind  = loop_test_pkg::rem_kind_t'(avm_writedata[`RCMD_KIND_HI:0]);
        next_st.rem_up    = avm_writedata[`RCMD_UP];
        next_st.rem_port  = avm_writedata[`RCMD_PORT];
        // line code lasts its fixed time; channel codes a shorter burst
        next_st.rem_count = (avm_writedata[`RCMD_KIND_HI:0] == 2'h0)
                            ? LINE_CODE_CYCLES - 32'h0000_0001
                            : CHAN_CODE_CYCLES - 32'h0000_0001;
      end
    end

    // line side: jack insert has the last word on the wire
    next_st.line_tx = jack_line_in_plug ? jack_line_in
                      : st.active[`ACT_LINE] ? rx_line : fr_net_tx;
    // repeater loop turns outbound framed data back before the line
    next_st.fr_net_rx = st.active[`ACT_REPEATER] ? fr_net_tx : rx_line;

    // equipment side
    next_st.dte_tx = jack_equip_in_plug ? jack_equip_in
                     : st.active[`ACT_EQUIP] ? rx_dte : fr_dte_tx;
    // payload loop feeds framed receive data back into the framer, which
    // rebuilds CRCs and drops bipolar_violation errors on the way out
    next_st.fr_dte_rx = st.active[`ACT_PAYLOAD] ? fr_dte_tx : rx_dte;

    // data ports: channel loop stays inside, terminal loop skips the framer
    for (int p = 0; p < 2; p++)
    begin
      next_st.port_tx[p] = st.active[`ACT_TERM0 + p] ? port_rx[p]
                           : st.active[`ACT_CHAN0 + p] ? 1'b1 : fr_port_tx[p];
      next_st.fr_port_rx[p] = st.active[`ACT_CHAN0 + p] ? fr_port_tx[p]
                              : st.active[`ACT_TERM0 + p] ? 1'b1 : port_rx[p];
    end

    // monitor taps, aligned with the registered line and DTE outputs
    next_st.in_tap  = st.tap_line ? next_st.line_tx : next_st.dte_tx;
    next_st.out_tap = st.tap_line ? line_rx : dte_rx;
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st            <= '0;
      st.wait_req   <= 1'b1;
      st.xconn_en   <= 1'b1;
      st.line_tx    <= 1'b1;
      st.dte_tx     <= 1'b1;
      st.fr_net_rx  <= 1'b1;
      st.fr_dte_rx  <= 1'b1;
      st.port_tx    <= 2'h3;
      st.fr_port_rx <= 2'h3;
      st.in_tap     <= 1'b1;
      st.out_tap    <= 1'b1;
    end
    else if (ce)
      st <= next_st;
  end

  // outputs straight from the state register
  assign avm_readdata    = st.rdata;
  assign avm_waitrequest = st.wait_req;
  assign line_tx         = st.line_tx;
  assign dte_tx          = st.dte_tx;
  assign fr_net_rx       = st.fr_net_rx;
  assign fr_dte_rx       = st.fr_dte_rx;
  assign fr_port_rx      = st.fr_port_rx;
  assign port_tx         = st.port_tx;
  assign input_tap       = st.in_tap;
  assign output_tap      = st.out_tap;
  assign rem_send        = st.rem_busy;
  assign rem_kind        = st.rem_kind;
  assign rem_up          = st.rem_up;
  assign rem_port        = st.rem_port;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_two_loops_max: assert property ($countones(st.active) <= 2)
    else $error("more than two local loops active");

  a_line_loop_excl: assert property (st.active[`ACT_LINE] |->
    !st.active[`ACT_PAYLOAD] && st.active[5:4] == 2'h0)
    else $error("line loop beside payload or channel loop");

  a_equip_no_rep: assert property (st.active[`ACT_EQUIP] |->
    !st.active[`ACT_REPEATER])
    else $error("equipment loop beside repeater loop");

  a_rep_loop_excl: assert property (st.active[`ACT_REPEATER] |->
    !st.active[`ACT_PAYLOAD] && !st.active[`ACT_EQUIP] && st.active[5:4] == 2'h0)
    else $error("repeater loop beside excluded loop");

  a_chan_port_excl: assert property ((st.active[4] |-> !st.active[6])
    and (st.active[5] |-> !st.active[7]))
    else $error("channel and terminal loop on one port");

  a_line_loop_path: assert property (ce && st.active[`ACT_LINE] && !jack_line_in_plug
    && !jack_line_out_plug |=> st.line_tx == $past(line_rx))
    else $error("line loop did not return line receive");

  a_equip_loop_path: assert property (ce && st.active[`ACT_EQUIP]
    && !jack_equip_in_plug && !jack_equip_out_plug |=> st.dte_tx == $past(dte_rx))
    else $error("equipment loop did not return DTE receive");

  a_term_loop_path: assert property (ce && st.active[`ACT_TERM0]
    |=> st.port_tx[0] == $past(port_rx[0]) && st.fr_port_rx[0])
    else $error("terminal loop path wrong on port 0");

  a_tap_select: assert property (ce |=> st.in_tap ==
    ($past(st.tap_line) ? st.line_tx : st.dte_tx))
    else $error("input tap follows wrong signal");

  a_remote_refused: assert property (ce && rem_req && st.active != 8'h00
    && !st.rem_busy |=> st.invalid && !st.rem_busy)
    else $error("remote request accepted during local loop");

  a_remote_stops: assert property (ce && st.rem_busy && st.rem_count == 32'h0000_0000
    && !rem_req |=> !st.rem_busy)
    else $error("remote sequence did not stop");

  a_xconn_refuse: assert property (ce && loop_wr && avm_writedata[`LCMD_START]
    && !avm_writedata[`LCMD_STOP] && !avm_writedata[`LCMD_ABORT_ALL]
    && cmd_idx == `LIDX_EQUIP && !st.xconn_en && !st.active[`ACT_EQUIP]
    |=> !st.active[`ACT_EQUIP] ##0 st.invalid)
    else $error("equipment loop started with cross-connect off");

  a_out_tap_sel: assert property (ce |=> st.out_tap ==
    ($past(st.tap_line) ? $past(line_rx) : $past(dte_rx)))
    else $error("output tap follows wrong signal");

  // a cut line feeds the framer ones unless the repeater loop owns that wire
  a_line_jack_cut: assert property (ce && jack_line_out_plug
    && !st.active[`ACT_REPEATER] |=> st.fr_net_rx)
    else $error("line receive not cut by jack");

  a_line_jack_ins: assert property (ce && jack_line_in_plug
    |=> st.line_tx == $past(jack_line_in))
    else $error("line insert jack not driving the line");

  a_equip_jack_cut: assert property (ce && jack_equip_out_plug
    && !st.active[`ACT_PAYLOAD] |=> st.fr_dte_rx)
    else $error("DTE receive not cut by jack");

  a_equip_jack_ins: assert property (ce && jack_equip_in_plug
    |=> st.dte_tx == $past(jack_equip_in))
    else $error("equipment insert jack not driving the DTE");

  a_chan_loop_path: assert property (ce && st.active[`ACT_CHAN0]
    |=> st.fr_port_rx[0] == $past(fr_port_tx[0]) && st.port_tx[0])
    else $error("channel loop path wrong on port 0");

  // with the option off only a software write may raise these loops
  a_net_line_off: assert property (ce && !st.net_line_opt && !loop_wr
    && !st.active[`ACT_LINE] |=> !st.active[`ACT_LINE])
    else $error("network line command obeyed with option off");

  a_net_chan_off: assert property (ce && !st.net_chan_opt[1] && !loop_wr
    && !st.active[5] |=> !st.active[5])
    else $error("network channel command obeyed with option off");

  c_line_loop:  cover property (st.active[`ACT_LINE] && st.active[`ACT_EQUIP]);
  c_two_chans:  cover property (st.active[5:4] == 2'h3);
  c_remote_end: cover property (st.rem_busy ##1 !st.rem_busy);
  c_refused:    cover property (!st.invalid ##1 st.invalid);
  c_net_line:   cover property (net_line_up && st.net_line_opt);

endmodule

// [dv/line_partner.sv]
// network line, DTE and framer bit streams that feed the loopback controller
module line_partner (
  input  wire logic       clk,        // system clock
  input  wire logic       sys_rst,    // reset, high
  output logic            line_rx,    // bits from the network
  output logic            dte_rx,     // bits from the DTE
  output logic            fr_net_tx,  // framer toward network
  output logic            fr_dte_tx,  // framer toward DTE
  output logic [1:0]      fr_port_tx, // framer toward ports
  output logic [1:0]      port_rx     // bits entering ports
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] c;

  // free-running count, moves just after each edge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      c <= 4'h0;
    else
      c <= c + 4'h1;
  end

  // distinct patterns so a wrong routing shows up within a few cycles
  assign line_rx = c[0];
  assign dte_rx = c[0] ^ c[1];
  assign fr_net_tx = c[1];
  assign fr_dte_tx = c[2] ^ c[0];
  assign fr_port_tx = {c[3], c[2]};
  assign port_rx = {c[2] ^ c[1], c[3] ^ c[0]};
endmodule

// [dv/loopback_test_control_tb.sv]
// self-checking bench of the loopback controller
`include "loop_test_params.svh"
module loopback_test_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LINE_N = 20;
  localparam int CHAN_N = 10;
  localparam logic [7:0] EXCL [8] = '{8'h32, 8'h39, 8'h08, 8'h36, 8'h4B, 8'h8B, 8'h10, 8'h20};
  logic clk = 0, sys_rst = 1, avm_read = 0, avm_write = 0, avm_waitrequest;
  logic [3:0] avm_address = 4'h0;
  logic [31:0] avm_writedata = 32'h0, avm_readdata, rd;
  logic line_rx, line_tx, dte_rx, dte_tx, fr_net_tx, fr_net_rx, fr_dte_tx, fr_dte_rx;
  logic [1:0] fr_port_tx, fr_port_rx, port_rx, port_tx, net_v54_up = 0, net_v54_down = 0;
  logic jack_line_in_plug = 0, jack_line_in = 0, jack_line_out_plug = 0;
  logic jack_equip_in_plug = 0, jack_equip_in = 0, jack_equip_out_plug = 0;
  logic net_line_up = 0, net_line_down = 0, input_tap, output_tap, rem_send, rem_up, rem_port;
  loop_test_pkg::rem_kind_t rem_kind;
  logic [9:0] p_in;
  int errors = 0, comparisons = 0, cyc = 0, n;

  loopback_test_control #(.LINE_CODE_CYCLES(32'(LINE_N)), .CHAN_CODE_CYCLES(32'(CHAN_N)))
  loopback_test_control_inst (.clk, .sys_rst, .ce(1'b1), .avm_address, .avm_read, .avm_write,
    .avm_writedata, .avm_readdata, .avm_waitrequest, .line_rx, .line_tx, .dte_rx, .dte_tx,
    .fr_net_tx, .fr_net_rx, .fr_dte_tx, .fr_dte_rx, .fr_port_tx, .fr_port_rx, .port_rx,
    .port_tx, .jack_line_in_plug, .jack_line_in, .jack_line_out_plug, .jack_equip_in_plug,
    .jack_equip_in, .jack_equip_out_plug, .input_tap, .output_tap, .net_line_up,
    .net_line_down, .net_v54_up, .net_v54_down, .rem_send, .rem_kind, .rem_up, .rem_port);

  line_partner line_partner_inst (.clk, .sys_rst, .line_rx, .dte_rx, .fr_net_tx, .fr_dte_tx,
    .fr_port_tx, .port_rx);

  always #25 clk = ~clk;

  // inputs of the previous edge, which the registered outputs now show; hang guard
  always @(posedge clk)
  begin
    p_in <= {jack_equip_in, jack_line_in, port_rx, fr_port_tx, fr_dte_tx, fr_net_tx, dte_rx,
      line_rx};
    jack_line_in <= ~jack_line_in;
    jack_equip_in <= jack_line_in;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      conclude();
    end
  end

  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one Avalon transfer, held until waitrequest is sampled low; only the bench timeout ends a stall
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avm_address <= a;
    avm_writedata <= d;
    avm_write <= wr;
    avm_read <= !wr;
    do
      @(posedge clk);
    while (avm_waitrequest !== 1'b0);
    rd = avm_readdata;
    avm_write <= 1'b0;
    avm_read <= 1'b0;
  endtask

  // loop command word with start set, for an active-vector bit
  function automatic logic [31:0] lw(input int b);
    return 32'((b < 4 ? b : b < 6 ? 4 : 5) | ((b >= 4 && b % 2 == 1) ? 8 : 0) | 16);
  endfunction

  task automatic net_pulse(input logic [5:0] m);
    @(posedge clk);
    {net_v54_down, net_v54_up, net_line_down, net_line_up} <= m;
    @(posedge clk);
    {net_v54_down, net_v54_up, net_line_down, net_line_up} <= 6'h00;
  endtask

  task automatic stat(input logic [31:0] exp);
    bus(0, `REG_STATUS, 0);
    chk(rd & 32'h3FF, exp);
  endtask

  // data path of one loop alone
  task automatic path_chk(input int a);
    repeat (2) @(posedge clk);
    repeat (5)
    begin
      @(negedge clk);
      case (a)
        0: chk(line_tx, p_in[0]);
        1: chk(fr_dte_rx, p_in[3]);
        2: chk(dte_tx, p_in[1]);
        3: chk(fr_net_rx, p_in[2]);
        4, 5: chk(fr_port_rx[a - 4], p_in[a]);
        default: chk(port_tx[a - 6], p_in[a]);
      endcase
    end
  endtask

  task automatic clear_all;
    bus(1, `REG_LOOP_CMD, 32'h40);
    bus(1, `REG_STATUS, 32'h100);
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1, 4'h2, 32'hFFFFFFFF);
    bus(0, 4'h2, 0);
    chk(rd, 32'h0);
    bus(0, `REG_CTRL, 0);
    chk(rd, 32'h10);
    stat(32'h0);
    // taps, equipment then line, with all jacks plugged on the second pass
    repeat (4)
    begin
      @(negedge clk);
      chk(input_tap, dte_tx);
      chk(output_tap, p_in[1]);
    end
    bus(1, `REG_CTRL, 32'h11);
    jack_line_in_plug <= 1'b1;
    jack_line_out_plug <= 1'b1;
    jack_equip_in_plug <= 1'b1;
    jack_equip_out_plug <= 1'b1;
    repeat (2) @(posedge clk);
    repeat (4)
    begin
      @(negedge clk);
      chk(input_tap, line_tx);
      chk(output_tap, p_in[0]);
      chk({line_tx, fr_net_rx}, {p_in[8], 1'b1});
      chk({dte_tx, fr_dte_rx}, {p_in[9], 1'b1});
    end
    {jack_line_in_plug, jack_line_out_plug, jack_equip_in_plug, jack_equip_out_plug} <= 4'h0;
    bus(1, `REG_CTRL, 32'h10);
    // every ordered pair of loops
    for (int a = 0; a < 8; a++)
      for (int b = 0; b < 8; b++)
        if (a != b)
        begin
          bus(1, `REG_LOOP_CMD, lw(a));
          if (b == int'(a == 0))
            path_chk(a);
          bus(1, `REG_LOOP_CMD, lw(b));
          n = EXCL[a][b] ? 32'h100 | (1 << a) : (1 << a) | (1 << b);
          stat(n);
          clear_all();
        end
    bus(1, `REG_LOOP_CMD, lw(0));
    bus(1, `REG_LOOP_CMD, lw(2));
    bus(1, `REG_LOOP_CMD, lw(6));
    stat(32'h105);
    bus(1, `REG_LOOP_CMD, lw(0) + 16);
    stat(32'h104);
    clear_all();
    bus(1, `REG_CTRL, 32'h0);
    bus(1, `REG_LOOP_CMD, lw(2));
    stat(32'h100);
    bus(1, `REG_CTRL, 32'h10);
    bus(1, `REG_LOOP_CMD, lw(0));
    bus(1, `REG_STATUS, 32'h100);
    bus(1, `REG_REMOTE_CMD, 32'h14);
    stat(32'h101);
    chk(rem_send, 1'b0);
    clear_all();
    // remote codes: line, V.54 and fractional, down and up, port 1
    for (int k = 0; k < 6; k++)
    begin
      bus(1, `REG_REMOTE_CMD, 32'(24 | (k % 2) * 4 | k / 2));
      @(negedge clk);
      chk({rem_kind, rem_up, rem_port | k < 2}, {2'(k / 2), 1'(k % 2), 1'b1});
      n = 0;
      while (rem_send === 1'b1 && n < 100)
      begin
        n++;
        @(negedge clk);
      end
      chk(n, k < 2 ? LINE_N : CHAN_N);
    end
    // network commands, option off then on
    net_pulse(6'h01);
    stat(32'h0);
    bus(1, `REG_CTRL, 32'h12);
    net_pulse(6'h01);
    stat(32'h1);
    net_pulse(6'h02);
    stat(32'h0);
    bus(1, `REG_CTRL, 32'h10);
    net_pulse(6'h08);
    stat(32'h0);
    bus(1, `REG_CTRL, 32'h18);
    net_pulse(6'h08);
    stat(32'h20);
    net_pulse(6'h20);
    stat(32'h0);
    conclude();
  end
endmodule
